// >>> xhci_operational_regs.sv
// Operational register bank of the host controller
// Overview of operation
// - Command bits 11:7, 3:0 read/write
// - Status resets to 0000 0801h
// - Status error, ready, save/restore, halted read-only
// - Status bits 10, 4, 3, 2 clear on read
// - Page size reads one, read-only
// - Notify mask 15:0 read/write, resets zero
// - Ring control fields, resets zero
// - Context array pointer, resets zero
// - Reserved bits always read zero
// - Offsets decoded from BAR0 plus capability length
// - Command register resets to zero
`default_nettype none
module xhci_operational_regs
    import opregs_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic [31:0]    bar0_base,
    input  wire logic [7:0]     cap_length,
    input  wire mem_req_t       req,
    output logic [31:0]         rdata,
    output logic                rvalid,
    input  wire engine_status_t eng,
    output engine_ctrl_t        ctrl
);
    ////////////////////////////////////////////////////////////////////
    // Address decode
    logic [31:0] op_base;
    logic [31:0] rel;
    logic        hit_cmd;
    logic        hit_sts;
    logic        hit_page;
    logic        hit_notify;
    logic        hit_ring_lo;
    logic        hit_ring_hi;
    logic        hit_ctx_lo;
    logic        hit_ctx_hi;
    assign op_base     = bar0_base + {24'h000000, cap_length};
    assign rel         = req.addr - op_base;
    assign hit_cmd     = rel == OFS_COMMAND;
    assign hit_sts     = rel == OFS_STATUS;
    assign hit_page    = rel == OFS_PAGE_SIZE;
    assign hit_notify  = rel == OFS_NOTIFY;
    assign hit_ring_lo = rel == OFS_RING_LO;
    assign hit_ring_hi = rel == OFS_RING_HI;
    assign hit_ctx_lo  = rel == OFS_CTX_LO;
    assign hit_ctx_hi  = rel == OFS_CTX_HI;

    ////////////////////////////////////////////////////////////////////
    // Register state
    logic [31:0] command;
    logic        not_ready_flag;
    logic        halted_flag;
    logic        save_restore_error;
    logic        port_change_flag;
    logic        event_pending_flag;
    logic        system_error_flag;
    logic [15:0] notify_type_mask;
    logic [63:0] ring_ctl;
    logic [63:0] context_array_ptr;
    logic [7:0]  reset_cnt;
    logic        resetting;
    logic        wr_cmd;
    logic        sts_read;
    logic        reset_done;
    logic        soft_clear;
    logic [31:0] status_word;
    logic [31:0] next_rdata;

    assign wr_cmd     = req.wr && hit_cmd;
    assign sts_read   = req.rd && hit_sts;
    assign resetting  = reset_cnt != 8'h00;
    assign reset_done = reset_cnt == 8'h01;
    // Controller reset and light reset wipe the soft state
    assign soft_clear = command[CMD_CTRL_RESET] || command[CMD_LRST];

    // Command register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            command <= CMD_RESET;
        end else if (reset_done) begin
            command <= CMD_RESET;
        end else if (command[CMD_LRST]) begin
            command <= CMD_RESET;
        end else if (wr_cmd) begin
            command <= req.wdata & CMD_WMASK;
        end
    end

    // Internal reset sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reset_cnt <= RESET_COUNT;
        end else if (wr_cmd && req.wdata[CMD_CTRL_RESET] && !resetting) begin
            reset_cnt <= RESET_COUNT;
        end else if (resetting) begin
            reset_cnt <= reset_cnt - 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            not_ready_flag <= STS_RESET[11];
        end else begin
            not_ready_flag <= resetting && !reset_done;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halted_flag <= STS_RESET[0];
        end else begin
            halted_flag <= !command[CMD_RUN];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read-to-clear event flags; a new event wins over the clear
    function automatic logic rc_next(input logic cur, input logic ev,
                                     input logic rd, input logic clr);
        rc_next = ev || (cur && !rd && !clr);
    endfunction : rc_next

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            save_restore_error <= STS_RESET[10];
            port_change_flag   <= STS_RESET[4];
            event_pending_flag <= STS_RESET[3];
            system_error_flag  <= STS_RESET[2];
        end else begin
            save_restore_error <= rc_next(save_restore_error,
                eng.save_restore_fail, sts_read, soft_clear);
            port_change_flag   <= rc_next(port_change_flag,
                eng.port_change, sts_read, soft_clear);
            event_pending_flag <= rc_next(event_pending_flag,
                eng.event_irq, sts_read, soft_clear);
            system_error_flag  <= rc_next(system_error_flag,
                eng.system_error, sts_read, soft_clear);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Notification mask, ring control, context pointer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            notify_type_mask <= NOTIFY_RESET;
        end else if (command[CMD_CTRL_RESET]) begin
            notify_type_mask <= NOTIFY_RESET;
        end else if (req.wr && hit_notify) begin
            notify_type_mask <= req.wdata[15:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ring_ctl <= PTR64_RESET;
        end else if (soft_clear) begin
            ring_ctl <= PTR64_RESET;
        end else if (req.wr && hit_ring_lo) begin
            ring_ctl[31:0] <= {req.wdata[31:RING_PTR_LSB], 3'h0,
                               req.wdata[2:0]};
        end else if (req.wr && hit_ring_hi) begin
            ring_ctl[63:32] <= req.wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            context_array_ptr <= PTR64_RESET;
        end else if (command[CMD_CTRL_RESET]) begin
            context_array_ptr <= PTR64_RESET;
        end else if (req.wr && hit_ctx_lo) begin
            context_array_ptr[31:0] <=
                {req.wdata[31:CTX_PTR_LSB], 6'h00};
        end else if (req.wr && hit_ctx_hi) begin
            context_array_ptr[63:32] <= req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path
    assign status_word = {19'h00000, eng.ctrl_error, not_ready_flag,
                          save_restore_error, eng.restore_busy,
                          eng.save_busy, 3'h0, port_change_flag,
                          event_pending_flag, system_error_flag, 1'b0,
                          halted_flag};
    assign next_rdata =
        !req.rd     ? 32'h0000_0000 :
        hit_cmd     ? command :
        hit_sts     ? status_word :
        hit_page    ? PAGE_SIZE_VAL :
        hit_notify  ? {16'h0000, notify_type_mask} :
        hit_ring_lo ? {ring_ctl[31:4], eng.ring_running,
                       ring_ctl[2:0]} :
        hit_ring_hi ? ring_ctl[63:32] :
        hit_ctx_lo  ? context_array_ptr[31:0] :
        hit_ctx_hi  ? context_array_ptr[63:32] :
                      32'h0000_0000;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata  <= 32'h0000_0000;
            rvalid <= 1'b0;
        end else begin
            rdata  <= next_rdata;
            rvalid <= req.rd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control outputs to the engines
    assign ctrl.run                    = command[CMD_RUN];
    assign ctrl.controller_reset_cmd   = command[CMD_CTRL_RESET];
    assign ctrl.light_reset_cmd        = command[CMD_LRST];
    assign ctrl.save_state_cmd         = command[CMD_SAVE];
    assign ctrl.restore_state_cmd      = command[CMD_RESTORE];
    assign ctrl.interrupter_master_en  = command[CMD_IRQ_EN];
    assign ctrl.system_error_report_en = command[CMD_SERR_EN];
    assign ctrl.wrap_event_en          = command[CMD_WRAP];
    assign ctrl.u3_frame_index_halt_en = command[CMD_U3];
    assign ctrl.notify_type_mask       = notify_type_mask;
    assign ctrl.ring_dequeue_ptr       = {ring_ctl[63:RING_PTR_LSB],
                                          6'h00};
    assign ctrl.ring_abort_request     = ring_ctl[RING_ABORT];
    assign ctrl.ring_stop_request      = ring_ctl[RING_STOP];
    assign ctrl.ring_cycle_bit         = ring_ctl[RING_CYCLE];
    assign ctrl.context_array_ptr      = context_array_ptr;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_cmd_reserved: assert property (
        (command & ~CMD_WMASK) == 32'h0000_0000)
        else $error("command reserved bits set");
    a_page_const: assert property (
        req.rd && hit_page |=> rdata == 32'h0000_0001)
        else $error("page size not one");
    a_status_rsvd: assert property (
        req.rd && hit_sts |=> rdata[31:13] == 19'h0 && rdata[7:5] == 3'h0
            && rdata[1] == 1'b0)
        else $error("status reserved bits nonzero");
    a_rc_clears: assert property (
        sts_read && !eng.port_change |=> !port_change_flag)
        else $error("port change not cleared by read");
    a_rc_set_wins: assert property (
        eng.event_irq |=> event_pending_flag)
        else $error("event flag lost");
    a_halt_follows: assert property (
        !command[CMD_RUN] [*2] |-> halted_flag)
        else $error("halted flag not set while stopped");
    a_reset_clears: assert property (
        wr_cmd && req.wdata[CMD_CTRL_RESET] && !resetting
            |-> ##[1:21] !command[CMD_CTRL_RESET])
        else $error("controller reset never cleared");
    a_ready_after: assert property (
        $fell(command[CMD_CTRL_RESET]) |-> !not_ready_flag)
        else $error("still not ready after reset");
    a_ring_rsvd: assert property (
        req.rd && hit_ring_lo |=> rdata[5:4] == 2'h0)
        else $error("ring reserved bits nonzero");
    a_notify_write: assert property (
        req.wr && hit_notify && !command[CMD_CTRL_RESET]
            |=> notify_type_mask == $past(req.wdata[15:0]))
        else $error("notify mask not written");
    a_ctx_low_zero: assert property (
        context_array_ptr[5:0] == 6'h00)
        else $error("context pointer low bits nonzero");

    c_status_read: cover property (sts_read && event_pending_flag);
    c_hc_reset: cover property (reset_done);
    c_run: cover property ($rose(command[CMD_RUN]));
endmodule : xhci_operational_regs
`default_nettype wire

// >>> opregs_pkg.sv
// Constants and carrier types for the operational register bank
`default_nettype none
package opregs_pkg;
    // Byte offsets from the operational base
    localparam logic [31:0] OFS_COMMAND    = 32'h0000_0000;
    localparam logic [31:0] OFS_STATUS     = 32'h0000_0004;
    localparam logic [31:0] OFS_PAGE_SIZE  = 32'h0000_0008;
    localparam logic [31:0] OFS_NOTIFY     = 32'h0000_0014;
    localparam logic [31:0] OFS_RING_LO    = 32'h0000_0018;
    localparam logic [31:0] OFS_RING_HI    = 32'h0000_001c;
    localparam logic [31:0] OFS_CTX_LO     = 32'h0000_0030;
    localparam logic [31:0] OFS_CTX_HI     = 32'h0000_0034;
    // Command register bits
    localparam int CMD_RUN     = 0;
    localparam int CMD_CTRL_RESET = 1;
    localparam int CMD_IRQ_EN     = 2;
    localparam int CMD_SERR_EN    = 3;
    localparam int CMD_LRST    = 7;
    localparam int CMD_SAVE    = 8;
    localparam int CMD_RESTORE = 9;
    localparam int CMD_WRAP    = 10;
    localparam int CMD_U3      = 11;
    localparam logic [31:0] CMD_WMASK   = 32'h0000_0f8f;
    localparam logic [31:0] CMD_RESET   = 32'h0000_0000;
    // Status register reset value and bits
    localparam logic [31:0] STS_RESET   = 32'h0000_0801;
    // Page size field
    localparam logic [31:0] PAGE_SIZE_VAL = 32'h0000_0001;
    localparam logic [15:0] NOTIFY_RESET  = 16'h0000;
    localparam logic [63:0] PTR64_RESET   = 64'h0000_0000_0000_0000;
    localparam int RING_PTR_LSB = 6;
    localparam int RING_RUN_FLAG = 3;
    localparam int RING_ABORT    = 2;
    localparam int RING_STOP     = 1;
    localparam int RING_CYCLE    = 0;
    localparam int CTX_PTR_LSB  = 6;
    // Internal reset completion time
    localparam int CLK_PERIOD_NS = 5;
    localparam int RESET_TIME_NS = 100;
    localparam int RESET_CYCLES  =
        (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] RESET_COUNT = 8'(RESET_CYCLES);

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic save_busy;
        logic restore_busy;
        logic ctrl_error;
        logic ring_running;
        logic save_restore_fail;
        logic port_change;
        logic event_irq;
        logic system_error;
    } engine_status_t;

    typedef struct packed {
        logic        run;
        logic        controller_reset_cmd;
        logic        light_reset_cmd;
        logic        save_state_cmd;
        logic        restore_state_cmd;
        logic        interrupter_master_en;
        logic        system_error_report_en;
        logic        wrap_event_en;
        logic        u3_frame_index_halt_en;
        logic [15:0] notify_type_mask;
        logic [63:0] ring_dequeue_ptr;
        logic        ring_abort_request;
        logic        ring_stop_request;
        logic        ring_cycle_bit;
        logic [63:0] context_array_ptr;
    } engine_ctrl_t;
endpackage : opregs_pkg
`default_nettype wire

// >>> host_model.sv
// Host software model issuing operational register accesses
`default_nettype none
module host_model
    import opregs_pkg::*;
(
    input  wire logic [31:0] base,
    input  wire logic        clk,
    input  wire logic [31:0] rdata,
    input  wire logic        rvalid,
    output mem_req_t         req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    // One access: a one-cycle request, read data taken in the next cycle
    task automatic xfer(input logic wr, input logic [31:0] ofs,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        req <= '{rd: ~wr, wr: wr, addr: base + ofs, wdata: wd};
        @(posedge clk);
        // Released bus drops both strobes and shows the inverse of its last address and data
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
        #1;
        rd = rvalid ? rdata : 32'hx;
    endtask : xfer
endmodule : host_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the operational register bank
`default_nettype none
module tb_top
    import opregs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic        wr;
        logic [31:0] ofs;
        logic [31:0] wd;
        logic [31:0] exp;
    } row_t;

    localparam row_t ROWS [11] = '{
        '{1'b0, OFS_STATUS, 32'h0, 32'h0000_0801},
        '{1'b0, OFS_COMMAND, 32'h0, 32'h0000_0000},
        '{1'b0, OFS_PAGE_SIZE, 32'h0, 32'h0000_0001},
        '{1'b1, OFS_PAGE_SIZE, 32'hffff_ffff, 32'h0000_0001},
        '{1'b1, OFS_NOTIFY, 32'hffff_ffff, 32'h0000_ffff},
        '{1'b1, OFS_COMMAND, 32'h0000_0f7c, 32'h0000_0f0c},
        '{1'b1, OFS_RING_LO, 32'hffff_ffff, 32'hffff_ffc7},
        '{1'b1, OFS_RING_HI, 32'h1234_5678, 32'h1234_5678},
        '{1'b1, OFS_CTX_LO, 32'hffff_ffff, 32'hffff_ffc0},
        '{1'b1, OFS_CTX_HI, 32'ha5a5_a5a5, 32'ha5a5_a5a5},
        '{1'b1, 32'h0000_000c, 32'hffff_ffff, 32'h0000_0000}
    };

    logic           clk;
    logic           rst;
    logic [31:0]    bar0_base;
    logic [7:0]     cap_length;
    logic [31:0]    op_base;
    logic [31:0]    cmd_seen;
    mem_req_t       req;
    logic [31:0]    rdata;
    logic           rvalid;
    engine_status_t eng;
    engine_ctrl_t   ctrl;
    logic [31:0]    got;
    int             failures;
    int             cmp_count;
    int             cycles;

    assign op_base = bar0_base + 32'(cap_length);
    // Command controls as seen by the engines, in register bit order
    assign cmd_seen = {20'h00000, ctrl.u3_frame_index_halt_en,
                       ctrl.wrap_event_en, ctrl.restore_state_cmd,
                       ctrl.save_state_cmd, ctrl.light_reset_cmd, 3'h0,
                       ctrl.system_error_report_en,
                       ctrl.interrupter_master_en,
                       ctrl.controller_reset_cmd, ctrl.run};

    xhci_operational_regs uut (
        .clk        (clk),
        .rst        (rst),
        .bar0_base  (bar0_base),
        .cap_length (cap_length),
        .req        (req),
        .rdata      (rdata),
        .rvalid     (rvalid),
        .eng        (eng),
        .ctrl       (ctrl)
    );

    host_model u_host (
        .base   (op_base),
        .clk    (clk),
        .rdata  (rdata),
        .rvalid (rvalid),
        .req    (req)
    );

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            failures++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic rd(input logic [31:0] ofs);
        u_host.xfer(1'b0, ofs, 32'h0, got);
    endtask : rd

    task automatic wr(input logic [31:0] ofs, input logic [31:0] d);
        u_host.xfer(1'b1, ofs, d, got);
    endtask : wr

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // Cycle ceiling against a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        bar0_base = 32'h0000_1000;
        cap_length = 8'h20;
        eng = '0;
        failures = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        foreach (ROWS[i]) begin
            if (ROWS[i].wr) begin
                wr(ROWS[i].ofs, ROWS[i].wd);
            end
            rd(ROWS[i].ofs);
            check(got, ROWS[i].exp);
        end
        check({16'h0, ctrl.notify_type_mask}, 32'h0000_ffff);
        check(ctrl.context_array_ptr[63:32], 32'ha5a5_a5a5);
        check(ctrl.ring_dequeue_ptr[31:0], 32'hffff_ffc0);
        check(ctrl.ring_dequeue_ptr[63:32], 32'h1234_5678);
        check({31'h0, ctrl.ring_abort_request}, 32'h1);
        check({31'h0, ctrl.ring_stop_request}, 32'h1);
        check({31'h0, ctrl.ring_cycle_bit}, 32'h1);
        // Not ready cleared once the power-on phase is over
        repeat (10) @(posedge clk);
        rd(OFS_STATUS);
        check(got, 32'h0000_0001);
        // Events with levels, status write ignored, read clears flags
        @(posedge clk);
        eng <= 8'hff;
        @(posedge clk);
        eng <= 8'hf0;
        wr(OFS_STATUS, 32'h0000_0000);
        rd(OFS_STATUS);
        check(got, 32'h0000_171d);
        rd(OFS_STATUS);
        check(got, 32'h0000_1301);
        rd(OFS_RING_LO);
        check(got, 32'hffff_ffcf);
        @(posedge clk);
        eng <= 8'h00;
        // Event in the cycle of the clearing read is kept
        fork
            rd(OFS_STATUS);
            begin
                @(posedge clk);
                eng <= 8'h02;
                @(posedge clk);
                eng <= 8'h00;
            end
        join
        check(got, 32'h0000_0001);
        rd(OFS_STATUS);
        check(got, 32'h0000_0009);
        // Run clears halted
        wr(OFS_COMMAND, 32'h0000_0f0d);
        check(cmd_seen, 32'h0000_0f0d);
        rd(OFS_STATUS);
        check(got, 32'h0000_0000);
        // Decode follows a new base and capability length
        @(posedge clk);
        bar0_base <= 32'h8000_0000;
        cap_length <= 8'h40;
        rd(OFS_PAGE_SIZE);
        check(got, 32'h0000_0001);
        // Controller reset runs, then self-clears
        wr(OFS_COMMAND, 32'h0000_0002);
        rd(OFS_STATUS);
        check(got, 32'h0000_0801);
        repeat (25) @(posedge clk);
        rd(OFS_COMMAND);
        check(got, 32'h0000_0000);
        rd(OFS_NOTIFY);
        check(got, 32'h0000_0000);
        check(ctrl.context_array_ptr[63:32], 32'h0000_0000);
        rd(OFS_STATUS);
        check(got, 32'h0000_0001);
        // Light reset clears command and ring control
        wr(OFS_RING_LO, 32'hffff_ffff);
        check({31'h0, rvalid}, 32'h0);
        wr(OFS_COMMAND, 32'h0000_0081);
        @(posedge clk);
        rd(OFS_COMMAND);
        check(got, 32'h0000_0000);
        check(cmd_seen, 32'h0000_0000);
        rd(OFS_RING_LO);
        check(got, 32'h0000_0000);
        // Reset in mid-run restores status, notify mask, context pointer and command
        wr(OFS_NOTIFY, 32'h0000_00a5);
        wr(OFS_CTX_HI, 32'h0000_5a5a);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_STATUS);
        check(got, 32'h0000_0801);
        rd(OFS_NOTIFY);
        check(got, 32'h0000_0000);
        rd(OFS_CTX_HI);
        check(got, 32'h0000_0000);
        rd(OFS_COMMAND);
        check(got, 32'h0000_0000);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
